// ### core/lonp_pkg.sv
// constants, register map and carriers for the normalize path
// assumes a 32-bit AHB-Lite bus and a single 40 MHz clock
package lonp_pkg;
   localparam int unsigned lonp_data_w = 32;
   localparam int unsigned lonp_code_w = 5;
   localparam int unsigned lonp_half_w = 16;

   localparam logic [7:0] lonp_ctrl_addr = 8'h00;
   localparam logic [7:0] lonp_word_addr = 8'h04;
   localparam logic [7:0] lonp_result_addr = 8'h08;
   localparam logic [7:0] lonp_status_addr = 8'h0c;

   localparam logic [4:0] lonp_code_first = 5'h00;
   localparam logic [4:0] lonp_code_none = 5'h1f;
   localparam logic [1:0] lonp_trans_nonseq = 2'h2;

   typedef struct packed {
      logic [4:0] shift_code_in;
      logic right_dir;
      logic fill_mode;
      logic sign;
      logic output_stage_load_en;
      logic input_stage_load_en;
      logic output_stage_bypass;
      logic input_stage_bypass;
      logic half_select;
      logic auto_align_n;
   } lonp_ctrl_type;

   // control word width and reset value
   localparam int unsigned lonp_ctrl_w = 14;
   localparam logic [13:0] lonp_ctrl_reset = 14'h0001;

   typedef struct packed {
      logic [31:0] word;
      logic sign;
      logic [4:0] code;
   } lonp_in_stage_type;

   typedef struct packed {
      logic [31:0] arr;
      logic [4:0] enc;
   } lonp_out_stage_type;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
   } lonp_bus_phase_type;
endpackage : lonp_pkg

// ### core/lonp_top.sv
// leading-one normalize path: encoder, normalize mux, shift array, half mux
// assumes one AHB-Lite master on the same clock; registers hold all controls
//
// Contract
// - encoder code counts zeros above first one
// - encoder inputs are XORed with sign
// - sign inversion touches only encoder inputs
// - shift array shifts the raw word
// - auto-align asserted selects encoder code
// - auto-align high selects external shift code
// - half select picks upper or lower 16
// - bypass controls skip input or output stage
// - stages capture on rising clock edge
`timescale 1ns/10ps
`default_nettype none
module lonp_top
   import lonp_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [lonp_pkg::lonp_half_w-1:0] half_word_out_o,
   output logic [lonp_pkg::lonp_code_w-1:0] encoder_code_out_o
);
   import lonp_pkg::*;

   // highest set bit wins; all zero gives the last code
   function automatic logic [4:0] lonp_lead_one(input logic [31:0] v);
      logic [4:0] c;
      c = lonp_code_none;
      for (int i = 0; i < 32; i++)
      begin
         if (v[i])
         begin
            c = 5'(31 - i);
         end
      end
      return c;
   endfunction : lonp_lead_one

   // left shift device; fill right shift moves right by 32 minus code, filling with sign
   function automatic logic [31:0] lonp_shift(input logic [31:0] w, input logic [4:0] c,
                                              input logic fill, input logic rdir,
                                              input logic s);
      logic [63:0] dbl;
      logic [95:0] ext;
      logic [31:0] r;
      dbl = {w, w} << c;
      ext = {{32{s}}, w, 32'h0000_0000};
      if (!fill)
      begin
         r = dbl[63:32];
      end
      else if (!rdir)
      begin
         r = w << c;
      end
      else
      begin
         ext = ext >> (7'd64 - {2'b00, c});
         r = ext[31:0];
      end
      return r;
   endfunction : lonp_shift

   lonp_ctrl_type ctrl, next_ctrl;
   logic [31:0] word_reg, next_word_reg;
   lonp_in_stage_type in_q, next_in_q;
   lonp_out_stage_type out_q, next_out_q;
   lonp_bus_phase_type phase, next_phase;
   logic [31:0] next_hrdata;
   logic [15:0] next_half_word;
   logic [4:0] next_enc_out;

   logic [31:0] stage_word;
   logic stage_sign;
   logic [4:0] stage_code;
   logic [31:0] enc_in;
   logic [4:0] enc_code;
   logic [4:0] applied_code;
   logic [31:0] arr_out;
   logic [31:0] final_arr;
   logic [4:0] final_enc;
   logic [15:0] half_sel;
   logic addr_take;

   always_comb
   begin
      // input stage or its bypass
      stage_word = ctrl.input_stage_bypass ? word_reg : in_q.word;
      stage_sign = ctrl.input_stage_bypass ? ctrl.sign : in_q.sign;
      stage_code = ctrl.input_stage_bypass ? ctrl.shift_code_in : in_q.code;
      enc_in = stage_word ^ {32{stage_sign}};
      enc_code = lonp_lead_one(enc_in);
      applied_code = ctrl.auto_align_n ? stage_code : enc_code;
      arr_out = lonp_shift(stage_word, applied_code, ctrl.fill_mode, ctrl.right_dir,
                           stage_sign);
      final_arr = ctrl.output_stage_bypass ? arr_out : out_q.arr;
      final_enc = ctrl.output_stage_bypass ? enc_code : out_q.enc;
      half_sel = ctrl.half_select ? final_arr[31:16] : final_arr[15:0];
   end

   always_comb
   begin
      addr_take = hsel_i && hready_i && (htrans_i == lonp_trans_nonseq);
      next_ctrl = ctrl;
      next_word_reg = word_reg;
      next_in_q = in_q;
      next_out_q = out_q;
      next_hrdata = hrdata_o;
      next_half_word = half_sel;
      next_enc_out = final_enc;
      if (ctrl.input_stage_load_en)
      begin
         next_in_q.word = word_reg;
         next_in_q.sign = ctrl.sign;
         next_in_q.code = ctrl.shift_code_in;
      end
      if (ctrl.output_stage_load_en)
      begin
         next_out_q.arr = arr_out;
         next_out_q.enc = enc_code;
      end
      // data phase of a write
      if (phase.write)
      begin
         unique case (phase.addr)
            lonp_ctrl_addr: next_ctrl = lonp_ctrl_type'(hwdata_i[13:0]);
            lonp_word_addr: next_word_reg = hwdata_i;
            default: next_word_reg = word_reg;
         endcase
      end
      next_phase.write = addr_take && hwrite_i;
      next_phase.read = addr_take && !hwrite_i;
      next_phase.addr = haddr_i[7:0];
      if (addr_take && !hwrite_i)
      begin
         unique case (haddr_i[7:0])
            lonp_ctrl_addr: next_hrdata = {18'h00000, ctrl};
            lonp_word_addr: next_hrdata = word_reg;
            lonp_result_addr: next_hrdata = final_arr;
            lonp_status_addr: next_hrdata = {19'h00000, applied_code, 3'h0, final_enc};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!nrst_i)
      begin
         ctrl <= lonp_ctrl_type'(lonp_ctrl_reset);
         word_reg <= 32'h0000_0000;
         in_q <= '0;
         out_q <= '0;
         phase <= '0;
         hrdata_o <= 32'h0000_0000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         half_word_out_o <= 16'h0000;
         encoder_code_out_o <= 5'h00;
      end
      else
      begin
         ctrl <= next_ctrl;
         word_reg <= next_word_reg;
         in_q <= next_in_q;
         out_q <= next_out_q;
         phase <= next_phase;
         hrdata_o <= next_hrdata;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         half_word_out_o <= next_half_word;
         encoder_code_out_o <= next_enc_out;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_enc_all_zero: assert property (enc_in == 32'h0000_0000 |-> enc_code == 5'h1f)
      else $error("encoder code wrong for zero input");
   a_enc_top_bit: assert property (enc_in[31] |-> enc_code == lonp_code_first)
      else $error("encoder code wrong for top bit");
   a_enc_sign_xor: assert property ((stage_word[31] != stage_sign) |-> enc_code == 5'h00)
      else $error("sign inversion not applied");
   a_array_raw_word: assert property (ctrl.auto_align_n && !ctrl.fill_mode
                                      && stage_code == 5'h00 |-> arr_out == stage_word)
      else $error("array does not see raw word");
   a_align_code_sel: assert property (!ctrl.auto_align_n |-> applied_code == enc_code)
      else $error("auto-align does not use encoder code");
   a_ext_code_sel: assert property (ctrl.auto_align_n |-> applied_code == stage_code)
      else $error("external code not applied");
   a_half_pins: assert property (##1 half_word_out_o ==
                                 ($past(ctrl.half_select) ? $past(final_arr[31:16])
                                                          : $past(final_arr[15:0])))
      else $error("half word pins disagree with select");
   a_in_stage_hold: assert property (!ctrl.input_stage_load_en ##1 ctrl.input_stage_bypass == 1'b0
                                     |-> $stable(in_q))
      else $error("input stage changed without load");
   a_out_stage_load: assert property (ctrl.output_stage_load_en
                                      |=> out_q.arr == $past(arr_out)
                                          && out_q.enc == $past(enc_code))
      else $error("output stage failed to load");
   a_bypass_out: assert property (ctrl.output_stage_bypass |-> final_enc == enc_code)
      else $error("output bypass not taken");
   a_enc_port: assert property (##1 encoder_code_out_o == $past(final_enc))
      else $error("encoder port does not follow code");

   // encoder: lowest bit alone and the count itself
   a_enc_low_bit: assert property (enc_in == 32'h0000_0001 |-> enc_code == lonp_code_none)
      else $error("encoder code wrong for bottom bit");

   a_enc_lead_set: assert property (enc_in != 32'h0000_0000
                                    |-> enc_in[5'd31 - enc_code] == 1'b1)
      else $error("encoder code does not point at a one");

   a_enc_above_zero: assert property (enc_in != 32'h0000_0000
                                      |-> (enc_in >> (6'd32 - {1'b0, enc_code})) == 32'h0)
      else $error("ones above the encoded position");

   // sign inverts only the encoder inputs
   a_enc_sign_inv: assert property (stage_sign |-> enc_in == ~stage_word)
      else $error("negative word not inverted for encoder");

   a_enc_sign_pass: assert property (!stage_sign |-> enc_in == stage_word)
      else $error("positive word altered for encoder");

   a_wrap_raw: assert property (ctrl.auto_align_n && !ctrl.fill_mode
                                |-> arr_out == ((stage_word << stage_code)
                                                | (stage_word >> (6'd32 - {1'b0, stage_code}))))
      else $error("wrap shift does not use raw word");

   a_fill_left: assert property (ctrl.fill_mode && !ctrl.right_dir
                                 |-> arr_out == (stage_word << applied_code))
      else $error("left fill shift wrong");

   // stage bypass and stage use
   a_bypass_in: assert property (ctrl.input_stage_bypass |-> stage_word == word_reg)
      else $error("input bypass not taken");

   a_stage_in_used: assert property (!ctrl.input_stage_bypass |-> stage_word == in_q.word)
      else $error("input stage not used");

   a_bypass_arr: assert property (ctrl.output_stage_bypass |-> final_arr == arr_out)
      else $error("output bypass not taken for array");

   a_stage_out_used: assert property (!ctrl.output_stage_bypass
                                      |-> final_arr == out_q.arr && final_enc == out_q.enc)
      else $error("output stage not used");

   // stage loading
   a_in_stage_load: assert property (ctrl.input_stage_load_en
                                     |=> in_q.word == $past(word_reg)
                                         && in_q.sign == $past(ctrl.sign)
                                         && in_q.code == $past(ctrl.shift_code_in))
      else $error("input stage failed to load");

   a_out_stage_hold: assert property (!ctrl.output_stage_load_en |=> $stable(out_q))
      else $error("output stage changed without load");

   // register bus
   a_ctrl_write: assert property (phase.write && phase.addr == lonp_ctrl_addr
                                  |=> ctrl == lonp_ctrl_type'($past(hwdata_i[13:0])))
      else $error("control write not stored");

   a_word_read: assert property (addr_take && !hwrite_i && haddr_i[7:0] == lonp_word_addr
                                 |=> hrdata_o == $past(word_reg))
      else $error("word read data wrong");

   a_result_read: assert property (addr_take && !hwrite_i && haddr_i[7:0] == lonp_result_addr
                                   |=> hrdata_o == $past(final_arr))
      else $error("result read data wrong");

   a_unmapped_read: assert property (addr_take && !hwrite_i && haddr_i[7:0] > lonp_status_addr
                                     |=> hrdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
endmodule : lonp_top
`default_nettype wire

// ### verification/lonp_host.sv
// partner: AHB-Lite master standing in for the host datapath logic
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/10ps
`default_nettype none
module lonp_host
   import lonp_pkg::*;
(
   input wire logic clk_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o,
   output logic stuck_o
);
   initial
   begin
      hsel_o = 1'b1;
      haddr_o = '0;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = '0;
      stuck_o = 1'b0;
   end

   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (hready_i !== 1'b1 && n < 50);
      if (hready_i !== 1'b1)
         stuck_o <= 1'b1;
   endtask : wait_ready

   // called right after a rising edge; ends on the edge that takes the data
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      haddr_o <= {24'h0, a};
      htrans_o <= lonp_trans_nonseq;
      hwrite_o <= wr;
      wait_ready();
      htrans_o <= 2'h0;
      hwdata_o <= wd;
      wait_ready();
      rd = hrdata_i;
      // released data bus shows no stale value
      hwdata_o <= ~wd;
   endtask : xfer
endmodule : lonp_host
`default_nettype wire

// ### verification/leading_one_normalize_path_bench.sv
// bench: register-level tests of the normalize path
// assumes the host model as sole bus master, 40 MHz clock
`timescale 1ns/10ps
`default_nettype none
module leading_one_normalize_path_bench;
   import lonp_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic hsel, hwrite, hready, hresp, stuck;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] half;
   logic [4:0] code, c;
   int mismatches = 0;
   int checks_done = 0;

   always #12.5 clk_i = ~clk_i;

   lonp_host u_lonp_host (.clk_i(clk_i), .hready_i(hready), .hrdata_i(hrdata),
      .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
      .hsize_o(hsize), .hwdata_o(hwdata), .stuck_o(stuck));
   lonp_top u_lonp_top (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .half_word_out_o(half), .encoder_code_out_o(code));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      u_lonp_host.xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      u_lonp_host.xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask : rd_chk

   task automatic final_report();
      if (stuck === 1'b1)
         mismatches++;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report

   always @(posedge stuck) final_report();

   initial
   begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      rd_chk("ctrl reset", lonp_ctrl_addr, 32'h1);
      rd_chk("unmapped", 8'h10, 32'h0);
      $display("test reset done");
      // auto-align, left fill, both stages bypassed, manual code 5 ignored
      wr(lonp_ctrl_addr, 32'ha8e);
      for (int k = 0; k < 33; k++)
      begin
         c = (k < 32) ? k[4:0] : 5'h1f;
         wr(lonp_word_addr, 32'h8000_0000 >> k);
         repeat (2) @(posedge clk_i);
         chk("code pin", {27'h0, c}, {27'h0, code});
         rd_chk("status", lonp_status_addr, {19'h0, c, 3'h0, c});
         rd_chk("result", lonp_result_addr, (k < 32) ? 32'h8000_0000 : 32'h0);
         chk("upper pin", (k < 32) ? 32'h8000 : 32'h0, {16'h0, half});
      end
      wr(lonp_ctrl_addr, 32'hace);
      wr(lonp_word_addr, 32'hfff0_ffff);
      repeat (2) @(posedge clk_i);
      chk("signed code", 32'hc, {27'h0, code});
      rd_chk("raw shift", lonp_result_addr, 32'h0fff_f000);
      wr(lonp_ctrl_addr, 32'hacc);
      repeat (2) @(posedge clk_i);
      chk("other half", 32'hf000, {16'h0, half});
      chk("other code", 32'hc, {27'h0, code});
      $display("test normalize done");
      wr(lonp_ctrl_addr, 32'h88f);
      wr(lonp_word_addr, 32'h1234_5678);
      repeat (2) @(posedge clk_i);
      rd_chk("manual", lonp_result_addr, 32'h2345_6780);
      chk("upper half", 32'h2345, {16'h0, half});
      wr(lonp_ctrl_addr, 32'h88d);
      repeat (2) @(posedge clk_i);
      chk("lower half", 32'h6780, {16'h0, half});
      $display("test manual done");
      wr(lonp_ctrl_addr, 32'h881);
      wr(lonp_word_addr, 32'hffff_ffff);
      repeat (3) @(posedge clk_i);
      rd_chk("held", lonp_result_addr, 32'h0);
      chk("held pin", 32'h0, {16'h0, half});
      wr(lonp_ctrl_addr, 32'h8b1);
      repeat (3) @(posedge clk_i);
      rd_chk("staged", lonp_result_addr, 32'hffff_fff0);
      chk("staged pin", 32'hfff0, {16'h0, half});
      chk("staged code", 32'h0, {27'h0, code});
      $display("test stages done");
      final_report();
   end
endmodule : leading_one_normalize_path_bench
`default_nettype wire
